// File: acsg_clock_ctrl.sv
// Purpose: clock source select, system divider and clock gates of the front end
// Assumes: APB slave, single clock, one wait state per transfer
// Notes: divided clock is a clock-enable style tick from the root clock input
//   the bus answers one cycle into the access phase, so penable stands for two cycles
//   a write commits at the edge where the master sees pready high; read data stands there too
//   unmapped offsets answer with pslverr, write nothing and read zero
//   the key opens the divider for the very next write only; reads keep the window open
//   a key write with any other value shuts the window like every other write
//   a divider write without the key completes normally and is dropped quietly
//   byte strobes apply per lane to the low 16 bits; the upper lanes carry nothing
//   reserved divider bits stay writable, software is trusted to keep them; gate bits 15:10 read zero
//   source, low-power and gate outputs trail their register by one clock
//   the extra flop keeps every output glitch free at the cost of one cycle of latency
//   limitation: the divided clock is an enable tick at the bus clock, not a clock of its own
//   a new divider value acts at the next edge, with no resync to the old tick phase
`timescale 1ns/1ps

module acsg_clock_ctrl
  import acsg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] system_clock_source,
  output logic [1:0] converter_clock_source,
  output logic [5:0] system_divide_ratio,
  output logic system_clock_tick,
  output logic chop_clock_off,
  output logic wake_timer_clock_off,
  output logic frontend_control_clock_off,
  output logic [15:0] clock_gate_enable
);
  import acsg_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] div_cfg_reg;
  logic [15:0] gate_reg;
  logic [15:0] src_sel_reg;
  logic [15:0] lp_en_reg;
  logic any_wr_done_w;
  logic key_match_w;
  logic div_wr_w;
  logic gate_wr_w;
  logic src_wr_w;
  logic lp_wr_w;
  logic [5:0] div_count_reg;
  logic [5:0] div_count_next;
  logic [5:0] ratio_next;
  logic access_w;
  logic wr_w;
  logic hit_w;
  logic [15:0] wmask_w;
  logic [15:0] rd_w;

  // access phase of an APB transfer, answered after one wait state
  assign access_w = psel & penable;
  assign wr_w = access_w & pwrite;
  // byte lanes apply to the low 16 bits only
  assign wmask_w = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // the key offset decodes as mapped so its write completes without an error
  // address decode and read mux
  always_comb begin
    hit_w = 1'b1;
    rd_w = 16'h0000;
    case (paddr)
      ACSG_OFF_DIV_CFG: rd_w = div_cfg_reg;
      ACSG_OFF_GATE: rd_w = gate_reg;
      ACSG_OFF_SRC_SEL: rd_w = src_sel_reg;
      ACSG_OFF_LP_EN: rd_w = lp_en_reg;
      ACSG_OFF_UNLOCK: rd_w = 16'h0000; // write-only key reads zero
      default: hit_w = 1'b0;
    endcase
  end

  // ack_reg blocks a second answer only in the cycle after the first; a penable held high longer is answered again
  // bus answer registered so outputs come from flops; one wait state results
  logic ack_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access_w & ~ack_reg;
    end
  end

  // ready, error and read data flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_w & ~ack_reg & ~pready;
      pslverr <= access_w & ~ack_reg & ~pready & ~hit_w;
      if (access_w & ~ack_reg & ~pwrite) begin
        prdata <= {16'h0000, rd_w};
      end
    end
  end

  // commit strobe: the edge at which the slave samples its own pready high
  logic commit_w;
  assign commit_w = wr_w & pready & hit_w;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  // every completed write, mapped or not, counts for the key window
  assign any_wr_done_w = wr_w & pready;
  // the key only opens on its exact 16-bit value
  assign key_match_w = any_wr_done_w && (paddr == ACSG_OFF_UNLOCK) && (pwdata[15:0] == ACSG_UNLOCK_VALUE);
  // one strobe per register keeps the decode in one place
  // unmapped writes never reach a register strobe because commit_w needs a hit
  assign div_wr_w = commit_w && (paddr == ACSG_OFF_DIV_CFG);
  assign gate_wr_w = commit_w && (paddr == ACSG_OFF_GATE);
  assign src_wr_w = commit_w && (paddr == ACSG_OFF_SRC_SEL);
  assign lp_wr_w = commit_w && (paddr == ACSG_OFF_LP_EN);

  // ----------------------------------------------------------------
  // key protection
  // ----------------------------------------------------------------
  // lock state: one key write opens the divider for the very next write only
  typedef enum logic [0:0] {
    ACSG_LOCKED = 1'b0,
    ACSG_UNLOCKED = 1'b1
  } acsg_lock_t;
  acsg_lock_t lock_state_reg;
  acsg_lock_t lock_state_next;

  // reads leave the window alone; each completed write decides the next state
  always_comb begin
    lock_state_next = lock_state_reg;
    case (lock_state_reg)
      ACSG_LOCKED: begin
        if (key_match_w) begin
          lock_state_next = ACSG_UNLOCKED;
        end
      end
      ACSG_UNLOCKED: begin
        // the divider write itself or any stray write shuts the window again
        if (any_wr_done_w && !key_match_w) begin
          lock_state_next = ACSG_LOCKED;
        end
      end
      default: begin
        lock_state_next = ACSG_LOCKED;
      end
    endcase
  end

  // resets closed, so a divider change always needs a fresh key
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lock_state_reg <= ACSG_LOCKED;
    end else begin
      lock_state_reg <= lock_state_next;
    end
  end

  // divider register; write ignored unless just unlocked
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cfg_reg <= ACSG_RST_DIV_CFG;
    end else if (div_wr_w && lock_state_reg == ACSG_UNLOCKED) begin
      div_cfg_reg <= (div_cfg_reg & ~wmask_w) | (pwdata[15:0] & wmask_w);
    end
  end

  // ----------------------------------------------------------------
  // source select and gates
  // ----------------------------------------------------------------
  // source fields; upper bits read zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel_reg <= ACSG_RST_SRC_SEL;
    end else if (src_wr_w) begin
      src_sel_reg <= (src_sel_reg & ~wmask_w) | (pwdata[15:0] & wmask_w & ACSG_SRC_SEL_MASK);
    end
  end

  // low-power enables; upper bits reserved read zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lp_en_reg <= ACSG_RST_LP_EN;
    end else if (lp_wr_w) begin
      lp_en_reg <= (lp_en_reg & ~wmask_w) | (pwdata[15:0] & wmask_w & ACSG_LP_EN_MASK);
    end
  end

  // gate register; bits 15:10 dropped on write and read zero, bits 9:0 writable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gate_reg <= ACSG_RST_GATE;
    end else if (gate_wr_w) begin
      gate_reg <= (gate_reg & ~wmask_w) | (pwdata[15:0] & wmask_w & ACSG_GATE_MASK);
    end
  end

  // ----------------------------------------------------------------
  // system divider
  // ----------------------------------------------------------------
  // the ratio is worked out from the stored field every cycle, so a new value acts at once
  // a count already past the new end wraps on the next edge, so a shrink leaves no long gap
  // the counter is never cleared by a write, which keeps the tick free of a restart glitch
  // saturate above 32, treat zero as one
  always_comb begin
    ratio_next = div_cfg_reg[ACSG_DIV_LSB +: ACSG_DIV_W];
    if (ratio_next > ACSG_DIV_MAX) begin
      ratio_next = ACSG_DIV_MAX;
    end else if (ratio_next < ACSG_DIV_ONE) begin
      ratio_next = ACSG_DIV_ONE;
    end
  end

  // counter wraps at ratio-1; tick marks one divided-clock period
  always_comb begin
    if (div_count_reg >= ratio_next - ACSG_DIV_ONE) begin
      div_count_next = 6'h00;
    end else begin
      div_count_next = div_count_reg + ACSG_DIV_ONE;
    end
  end

  // count, tick and ratio registered together so the ratio port matches the tick spacing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_count_reg <= 6'h00;
      system_clock_tick <= 1'b0;
      system_divide_ratio <= ACSG_DIV_ONE;
    end else begin
      div_count_reg <= div_count_next;
      system_clock_tick <= (div_count_next == 6'h00);
      system_divide_ratio <= ratio_next;
    end
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  // every output comes from a flop so downstream gating sees no decode glitch
  // source codes; every 2-bit value is a legal source, so no code needs trapping
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      system_clock_source <= ACSG_SRC_FAST_INTERNAL_OSCILLATOR;
      converter_clock_source <= ACSG_SRC_FAST_INTERNAL_OSCILLATOR;
    end else begin
      system_clock_source <= src_sel_reg[ACSG_SYS_SRC_LSB +: 2];
      converter_clock_source <= src_sel_reg[ACSG_ADC_SRC_LSB +: 2];
    end
  end

  // low-power gates; the chop clock starts off to save current until software wants it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chop_clock_off <= ACSG_RST_LP_EN[ACSG_CHOP_OFF_BIT];
      wake_timer_clock_off <= ACSG_RST_LP_EN[ACSG_WAKE_OFF_BIT];
    end else begin
      chop_clock_off <= lp_en_reg[ACSG_CHOP_OFF_BIT];
      wake_timer_clock_off <= lp_en_reg[ACSG_WAKE_OFF_BIT];
    end
  end

  // main control clock gate and a copy of the whole gate register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frontend_control_clock_off <= ACSG_RST_GATE[ACSG_FE_OFF_BIT];
      clock_gate_enable <= ACSG_RST_GATE;
    end else begin
      frontend_control_clock_off <= gate_reg[ACSG_FE_OFF_BIT];
      clock_gate_enable <= gate_reg;
    end
  end

endmodule // acsg_clock_ctrl

// File: acsg_clock_ctrl_assertions.sv
// Purpose: port relations of the clock select, divide and gate block
// Assumes: one wait state per apb transfer
// Notes: control outputs trail a committed write by two edges
`timescale 1ns/1ps
module acsg_clock_ctrl_checker
  import acsg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [1:0] system_clock_source,
  input wire logic [1:0] converter_clock_source,
  input wire logic [5:0] system_divide_ratio,
  input wire logic system_clock_tick,
  input wire logic chop_clock_off,
  input wire logic wake_timer_clock_off,
  input wire logic frontend_control_clock_off,
  input wire logic [15:0] clock_gate_enable
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic wr_ok;
  // commit edge of a low-byte write
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_rst_state: assert property ($fell(sys_rst) |-> chop_clock_off && !wake_timer_clock_off
    && system_clock_source == 2'b00 && system_divide_ratio == 6'h01 && clock_gate_enable == ACSG_RST_GATE)
    else $error("bad state after reset");
  chk_ratio_bounds: assert property (system_divide_ratio inside {[6'h01:6'h20]})
    else $error("ratio out of range");
  chk_tick_undivided: assert property (system_divide_ratio == 6'h01 ##1 system_divide_ratio == 6'h01
    |-> system_clock_tick) else $error("tick missing at ratio one");
  chk_tick_by_two: assert property (system_clock_tick && system_divide_ratio == 6'h02
    ##1 system_divide_ratio == 6'h02 ##1 system_divide_ratio == 6'h02 |-> system_clock_tick && !$past(system_clock_tick))
    else $error("tick spacing wrong at ratio two");
  chk_ready_latency: assert property (psel && penable && !pready |=> pready)
    else $error("answer late");
  chk_lp_follow: assert property (wr_ok && paddr == ACSG_OFF_LP_EN |-> ##2
    chop_clock_off == $past(pwdata[2], 2) && wake_timer_clock_off == $past(pwdata[1], 2))
    else $error("low power gates wrong");
  chk_gate_follow: assert property (wr_ok && paddr == ACSG_OFF_GATE |-> ##2
    frontend_control_clock_off == $past(pwdata[5], 2)) else $error("control clock gate wrong");
  chk_src_follow: assert property (wr_ok && paddr == ACSG_OFF_SRC_SEL |-> ##2
    system_clock_source == $past(pwdata[1:0], 2) && converter_clock_source == $past(pwdata[3:2], 2))
    else $error("source select wrong");
  cover property (system_divide_ratio == 6'h20);
  cover property (system_clock_tick && system_divide_ratio == 6'h03);
  cover property (wr_ok && paddr == ACSG_OFF_DIV_CFG);
endmodule // acsg_clock_ctrl_checker

bind acsg_clock_ctrl acsg_clock_ctrl_checker u_chk (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .system_clock_source, .converter_clock_source, .system_divide_ratio, .system_clock_tick,
  .chop_clock_off, .wake_timer_clock_off, .frontend_control_clock_off, .clock_gate_enable);

// File: acsg_clock_ctrl_tb.sv
// Purpose: apb bench for the clock select, divide and gate block
// Assumes: the slave answers within a few cycles
// Notes: one idle cycle between transfers keeps drivers single-assigned
`timescale 1ns/1ps
module acsg_clock_ctrl_tb;
  import acsg_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h3;
  logic pready, pslverr, system_clock_tick, chop_clock_off, wake_timer_clock_off, frontend_control_clock_off, er;
  logic [1:0] system_clock_source, converter_clock_source;
  logic [5:0] system_divide_ratio;
  logic [15:0] clock_gate_enable;
  logic [5:0] dv [6] = '{6'h00, 6'h01, 6'h02, 6'h20, 6'h21, 6'h3f};
  logic [5:0] ex [6] = '{6'h01, 6'h01, 6'h02, 6'h20, 6'h20, 6'h20};
  int n_mismatch = 0, total_checks = 0;
  logic [31:0] cnt;
  // ----------------------------------------------------------------
  // clock, design and access tasks
  // ----------------------------------------------------------------
  always #10 clock = ~clock;
  acsg_clock_ctrl dut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .system_clock_source, .converter_clock_source, .system_divide_ratio, .system_clock_tick,
    .chop_clock_off, .wake_timer_clock_off, .frontend_control_clock_off, .clock_gate_enable);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    if (n >= 9) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog, far beyond the 94 transfers
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(ACSG_OFF_DIV_CFG, 32'h0441);
    rd_chk(ACSG_OFF_GATE, 32'h01c0);
    rd_chk(ACSG_OFF_SRC_SEL, 32'h0);
    rd_chk(ACSG_OFF_LP_EN, 32'h4);
    rd_chk(ACSG_OFF_UNLOCK, 32'h0);
    wr(ACSG_OFF_DIV_CFG, 32'h0445);
    rd_chk(ACSG_OFF_DIV_CFG, 32'h0441);
    for (int i = 0; i < 6; i++) begin
      wr(ACSG_OFF_UNLOCK, 32'ha815);
      wr(ACSG_OFF_DIV_CFG, {26'h11, dv[i]});
      rd_chk(ACSG_OFF_DIV_CFG, {26'h11, dv[i]});
      repeat (3) @(posedge clock);
      chk(system_divide_ratio, ex[i]);
    end
    // a write between key and divider relocks
    wr(ACSG_OFF_UNLOCK, 32'ha815);
    wr(ACSG_OFF_GATE, 32'h01c9);
    wr(ACSG_OFF_DIV_CFG, 32'h0443);
    rd_chk(ACSG_OFF_DIV_CFG, 32'h047f);
    wr(ACSG_OFF_UNLOCK, 32'ha815);
    wr(ACSG_OFF_DIV_CFG, 32'h0443);
    wr(ACSG_OFF_DIV_CFG, 32'h0445);
    rd_chk(ACSG_OFF_DIV_CFG, 32'h0443);
    cnt = 0;
    repeat (30) begin
      @(posedge clock);
      cnt += system_clock_tick;
    end
    chk(cnt, 32'ha);
    for (int i = 0; i < 16; i++) begin
      wr(ACSG_OFF_SRC_SEL, 32'hfff0 | i);
      rd_chk(ACSG_OFF_SRC_SEL, i);
      chk(system_clock_source, i % 4);
      chk(converter_clock_source, i / 4);
    end
    wr(ACSG_OFF_SRC_SEL, 32'h0);
    rd_chk(ACSG_OFF_SRC_SEL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(ACSG_OFF_LP_EN, 32'hfff8 | i);
      rd_chk(ACSG_OFF_LP_EN, i);
      chk({chop_clock_off, wake_timer_clock_off}, i / 2);
    end
    for (int i = 0; i < 2; i++) begin
      wr(ACSG_OFF_GATE, 32'hfdc9 | (i << 5));
      rd_chk(ACSG_OFF_GATE, 32'h01c9 | (i << 5));
      chk(clock_gate_enable, 32'h01c9 | (i << 5));
      chk(frontend_control_clock_off, i);
    end
    // only the low lane enabled: the upper byte of the gate register keeps its value
    pstrb <= 4'h1;
    wr(ACSG_OFF_GATE, 32'h0000_00c9);
    rd_chk(ACSG_OFF_GATE, 32'h01c9);
    chk(frontend_control_clock_off, 1'b0);
    pstrb <= 4'h3;
    // a read between key and divider leaves the key window open
    wr(ACSG_OFF_UNLOCK, 32'ha815);
    rd_chk(ACSG_OFF_UNLOCK, 32'h0);
    wr(ACSG_OFF_DIV_CFG, 32'h0442);
    rd_chk(ACSG_OFF_DIV_CFG, 32'h0442);
    apb(1'b0, 12'h000, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    results();
  end
endmodule // acsg_clock_ctrl_tb

// File: acsg_pkg.sv
// Purpose: shared constants for the front-end clock select, divide and gate block
// Assumes: APB slave with 32-bit data, registers in the low 16 bits
// Notes: offsets are byte addresses
package acsg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ACSG_OFF_DIV_CFG = 12'h408;
  localparam logic [11:0] ACSG_OFF_GATE = 12'h410;
  localparam logic [11:0] ACSG_OFF_SRC_SEL = 12'h414;
  localparam logic [11:0] ACSG_OFF_UNLOCK = 12'h420;
  localparam logic [11:0] ACSG_OFF_LP_EN = 12'ha70;

  // ----------------------------------------------------------------
  // reset values, key and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] ACSG_RST_DIV_CFG = 16'h0441;
  localparam logic [15:0] ACSG_RST_GATE = 16'h01c0;
  localparam logic [15:0] ACSG_RST_SRC_SEL = 16'h0000;
  localparam logic [15:0] ACSG_RST_LP_EN = 16'h0004;
  localparam logic [15:0] ACSG_UNLOCK_VALUE = 16'ha815;
  localparam logic [5:0] ACSG_DIV_MAX = 6'h20;
  localparam logic [5:0] ACSG_DIV_ONE = 6'h01;
  localparam int ACSG_DIV_LSB = 0;
  localparam int ACSG_DIV_W = 6;
  localparam int ACSG_SYS_SRC_LSB = 0;
  localparam int ACSG_ADC_SRC_LSB = 2;
  localparam int ACSG_WAKE_OFF_BIT = 1;
  localparam int ACSG_CHOP_OFF_BIT = 2;
  localparam int ACSG_FE_OFF_BIT = 5;
  localparam logic [15:0] ACSG_SRC_SEL_MASK = 16'h000f;
  localparam logic [15:0] ACSG_LP_EN_MASK = 16'h0007;
  localparam logic [15:0] ACSG_GATE_MASK = 16'h03ff;
  localparam int ACSG_ROOT_MHZ = 16;

  // ----------------------------------------------------------------
  // clock source codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACSG_SRC_FAST_INTERNAL_OSCILLATOR = 2'b00,
    ACSG_SRC_CRYSTAL = 2'b01,
    ACSG_SRC_SLOW_INTERNAL_OSCILLATOR = 2'b10,
    ACSG_SRC_EXTERNAL = 2'b11
  } acsg_src_t;

endpackage
